// ==== verilog/ecc_dpram_defs.svh ====
/*
 Constants for the error-corrected dual-port RAM: widths, depth, code layout.
 Assumes nothing; included by the package and the top module.
*/
`ifndef ECC_DPRAM_DEFS_SVH
`define ECC_DPRAM_DEFS_SVH

`define ADDR_W 4
`define DATA_W 8
`define CODE_W 13
`define HAM_W 12
`define SYN_W 4
`define DEPTH 16
`define INJECT_BIT 0
`define OVERALL_BIT 12

`endif

// ==== verilog/ecc_dpram_pkg.sv ====
/*
 Types for the error-corrected dual-port RAM.
 Assumes the constants header is on the include path.
*/
`include "ecc_dpram_defs.svh"

package ecc_dpram_pkg;

    // One port's request as it walks the write pipeline
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic wr_en;
        logic rd_en;
        logic [`CODE_W-1:0] code;
    } port_req_t;

    // Decoder result
    typedef struct packed {
        logic [`DATA_W-1:0] data;
        logic fixed;
        logic found;
        logic fatal;
    } dec_result_t;

endpackage : ecc_dpram_pkg

// ==== verilog/ecc_protected_dual_port_ram.sv ====
/*
 Two-port RAM of SECDED-coded words: per-port encoder, two-stage memory, decoder.
 Assumes both ports are driven synchronously to clock and never write
 different data to one address in the same cycle.
*/
// Function
// - One shared clock for every stage
// - Inject flips LSB of port one code
// - Control bits delayed to match encoder
// - Read data four cycles after issue
// - Same-port: one new data, two old
// - Cross-port write-read returns old contents
// - Later read returns latest written value
// - Undefined code word gives undefined flags
// - Decoder corrects single-bit error on output
// - Single error raises fixed and found
// - Stored word stays corrupted until rewritten
// - Each port outputs data and three flags
// - Outcomes: clean, corrected, or fatal
// - Sixteen words, 8-bit data, 13-bit code
`timescale 1ns/100ps
`include "ecc_dpram_defs.svh"

module ecc_protected_dual_port_ram
    import ecc_dpram_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic inject_lsb_error_port_one,
    input wire logic [`ADDR_W-1:0] port_one_addr,
    input wire logic [`DATA_W-1:0] port_one_wdata,
    input wire logic port_one_wr_en,
    input wire logic port_one_rd_en,
    input wire logic [`ADDR_W-1:0] port_two_addr,
    input wire logic [`DATA_W-1:0] port_two_wdata,
    input wire logic port_two_wr_en,
    input wire logic port_two_rd_en,
    output var logic [`DATA_W-1:0] port_one_rd_out,
    output var logic port_one_fixed_flag,
    output var logic port_one_found_flag,
    output var logic port_one_uncorrectable_flag,
    output var logic [`DATA_W-1:0] port_two_rd_out,
    output var logic port_two_fixed_flag,
    output var logic port_two_found_flag,
    output var logic port_two_uncorrectable_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Code functions

    // Power-of-two positions hold check bits
    function automatic logic is_check_pos(input integer pos);
        is_check_pos = ((pos & (pos - 1)) == 0);
    endfunction : is_check_pos

    function automatic logic [`CODE_W-1:0] encode(input logic [`DATA_W-1:0] d);
        logic [`CODE_W-1:0] c;
        integer i;
        integer k;
        integer j;
        c = '0;
        j = 0;
        for (i = 1; i <= `HAM_W; i++)
        begin
            if (!is_check_pos(i))
            begin
                c[i-1] = d[j];
                j++;
            end
        end
        for (k = 0; k < `SYN_W; k++)
        begin
            for (i = 1; i <= `HAM_W; i++)
            begin
                if (i[k] && !is_check_pos(i))
                begin
                    c[(1 << k) - 1] = c[(1 << k) - 1] ^ c[i-1];
                end
            end
        end
        c[`OVERALL_BIT] = ^c[`HAM_W-1:0];
        encode = c;
    endfunction : encode

    // Flags are xor, and and or of the word, so an unknown word yields unknown flags
    function automatic dec_result_t decode(input logic [`CODE_W-1:0] c);
        dec_result_t r;
        logic [`SYN_W-1:0] s;
        logic [`HAM_W-1:0] m;
        logic [`HAM_W-1:0] w;
        logic ov;
        integer i;
        integer k;
        integer j;
        r = '0;
        s = '0;
        m = '0;
        j = 0;
        for (i = 1; i <= `HAM_W; i++)
        begin
            for (k = 0; k < `SYN_W; k++)
            begin
                if (i[k])
                begin
                    s[k] = s[k] ^ c[i-1];
                end
            end
        end
        ov = ^c;
        for (i = 1; i <= `HAM_W; i++)
        begin
            m[i-1] = ov & (s == i[`SYN_W-1:0]);
        end
        w = c[`HAM_W-1:0] ^ m;
        for (i = 1; i <= `HAM_W; i++)
        begin
            if (!is_check_pos(i))
            begin
                r.data[j] = w[i-1];
                j++;
            end
        end
        r.fixed = ov;
        r.found = ov | (|s);
        r.fatal = ~ov & (|s);
        decode = r;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    // Stage 1: encoders, controls ride alongside

    port_req_t one_enc_q;
    port_req_t two_enc_q;
    port_req_t one_ram_q;
    port_req_t two_ram_q;
    logic [`CODE_W-1:0] one_code_d;

    // Flip after encoding, so the stored word carries a real single error
    always_comb
    begin
        one_code_d = encode(port_one_wdata);
        one_code_d[`INJECT_BIT] = one_code_d[`INJECT_BIT] ^ inject_lsb_error_port_one;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            one_enc_q <= '0;
        end
        else
        begin
            one_enc_q.addr <= port_one_addr;
            one_enc_q.wr_en <= port_one_wr_en;
            one_enc_q.rd_en <= port_one_rd_en;
            one_enc_q.code <= one_code_d;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            two_enc_q <= '0;
        end
        else
        begin
            two_enc_q.addr <= port_two_addr;
            two_enc_q.wr_en <= port_two_wr_en;
            two_enc_q.rd_en <= port_two_rd_en;
            two_enc_q.code <= encode(port_two_wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 2: memory input registers

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            one_ram_q <= '0;
            two_ram_q <= '0;
        end
        else
        begin
            one_ram_q <= one_enc_q;
            two_ram_q <= two_enc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 3: array and read output registers

    // Array has no reset; contents power up unknown
    logic [`CODE_W-1:0] mem [`DEPTH];
    logic [`CODE_W-1:0] one_rd_q;
    logic [`CODE_W-1:0] two_rd_q;
    logic clash;

    assign clash = one_ram_q.wr_en && two_ram_q.wr_en &&
                   (one_ram_q.addr == two_ram_q.addr) &&
                   (one_ram_q.code != two_ram_q.code);

    // Only the write path touches the array; correction never writes back
    always_ff @(posedge clock)
    begin
        if (one_ram_q.wr_en)
        begin
            mem[one_ram_q.addr] <= one_ram_q.code;
        end
        if (two_ram_q.wr_en)
        begin
            mem[two_ram_q.addr] <= two_ram_q.code;
        end
        if (clash)
        begin
            mem[one_ram_q.addr] <= {`CODE_W{1'bx}};
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            one_rd_q <= '0;
        end
        else if (one_ram_q.rd_en)
        begin
            if (one_ram_q.wr_en)
            begin
                one_rd_q <= one_ram_q.code;
            end
            else
            begin
                one_rd_q <= mem[one_ram_q.addr];
            end
        end
    end

    // Nonblocking array update means the read sees pre-write contents
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            two_rd_q <= '0;
        end
        else if (two_ram_q.rd_en)
        begin
            two_rd_q <= mem[two_ram_q.addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 4: decoders drive the outputs

    dec_result_t one_dec;
    dec_result_t two_dec;

    assign one_dec = decode(one_rd_q);
    assign two_dec = decode(two_rd_q);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            port_one_rd_out <= '0;
            port_one_fixed_flag <= 1'b0;
            port_one_found_flag <= 1'b0;
            port_one_uncorrectable_flag <= 1'b0;
        end
        else
        begin
            port_one_rd_out <= one_dec.data;
            port_one_fixed_flag <= one_dec.fixed;
            port_one_found_flag <= one_dec.found;
            port_one_uncorrectable_flag <= one_dec.fatal;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            port_two_rd_out <= '0;
            port_two_fixed_flag <= 1'b0;
            port_two_found_flag <= 1'b0;
            port_two_uncorrectable_flag <= 1'b0;
        end
        else
        begin
            port_two_rd_out <= two_dec.data;
            port_two_fixed_flag <= two_dec.fixed;
            port_two_found_flag <= two_dec.found;
            port_two_uncorrectable_flag <= two_dec.fatal;
        end
    end

endmodule : ecc_protected_dual_port_ram

// ==== testbench/ecc_dpram_assertions.sv ====
/*
 Port checker for the coded dual-port RAM.
 Assumes resetn is held low before any traffic.
*/
`timescale 1ns/100ps
`include "ecc_dpram_defs.svh"
module ecc_dpram_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic inject_lsb_error_port_one,
    input wire logic [`DATA_W-1:0] port_one_wdata,
    input wire logic port_one_wr_en,
    input wire logic port_one_rd_en,
    input wire logic port_two_rd_en,
    input wire logic [`DATA_W-1:0] port_one_rd_out,
    input wire logic port_one_fixed_flag,
    input wire logic port_one_found_flag,
    input wire logic port_one_uncorrectable_flag,
    input wire logic [`DATA_W-1:0] port_two_rd_out,
    input wire logic port_two_fixed_flag,
    input wire logic port_two_found_flag,
    input wire logic port_two_uncorrectable_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    a_one_fix_found: assert property (port_one_fixed_flag |-> port_one_found_flag)
        else $error("port one fixed without found");
    a_two_fix_found: assert property (port_two_fixed_flag |-> port_two_found_flag)
        else $error("port two fixed without found");
    a_one_fatal_only: assert property (port_one_uncorrectable_flag |->
        port_one_found_flag && !port_one_fixed_flag) else $error("port one bad fatal");
    a_two_fatal_only: assert property (port_two_uncorrectable_flag |->
        port_two_found_flag && !port_two_fixed_flag) else $error("port two bad fatal");
    // Data and fixed flag may only move four edges after a read
    a_one_out_hold: assert property (!$past(port_one_rd_en, 4) |->
        $stable({port_one_rd_out, port_one_fixed_flag})) else $error("port one moved");
    a_two_out_hold: assert property (!$past(port_two_rd_en, 4) |->
        $stable({port_two_rd_out, port_two_fixed_flag})) else $error("port two moved");
    a_inject_fixed: assert property (inject_lsb_error_port_one && port_one_wr_en &&
        port_one_rd_en |-> ##4 port_one_fixed_flag) else $error("injection not fixed");
    a_one_new_data: assert property (port_one_wr_en && port_one_rd_en &&
        !inject_lsb_error_port_one |-> ##4 port_one_rd_out == $past(port_one_wdata, 4))
        else $error("port one lost new data");
    c_one_fixed: cover property (port_one_fixed_flag);
    c_two_fixed: cover property (port_two_fixed_flag);
    c_one_rdw: cover property (port_one_wr_en && port_one_rd_en);
endmodule : ecc_dpram_checker

bind ecc_protected_dual_port_ram ecc_dpram_checker u_chk (.clock, .resetn,
    .inject_lsb_error_port_one, .port_one_wdata, .port_one_wr_en, .port_one_rd_en,
    .port_two_rd_en, .port_one_rd_out, .port_one_fixed_flag, .port_one_found_flag,
    .port_one_uncorrectable_flag, .port_two_rd_out, .port_two_fixed_flag,
    .port_two_found_flag, .port_two_uncorrectable_flag);

// ==== testbench/ram_user_model.sv ====
/*
 User logic driving both RAM ports from a packed command.
 Assumes the bench changes cmd only after a rising edge.
*/
`timescale 1ns/100ps
module ram_user_model (
    input wire logic clock,
    input wire logic clash_ok,
    input wire logic [28:0] cmd,
    output var logic [28:0] pins
);
    logic [28:0] drive;
    initial pins = '0;
    always @(negedge clock)
    begin
        drive = cmd;
        // Dual write of differing data to one address would poison it
        if (!clash_ok && cmd[15] && cmd[1] && cmd[27:24] == cmd[13:10])
            drive[1] = 1'b0;
        pins <= drive;
    end
endmodule : ram_user_model

// ==== testbench/ecc_protected_dual_port_ram_tb_top.sv ====
/*
 Self-checking bench for the coded dual-port RAM.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module ecc_protected_dual_port_ram_tb_top;
    logic clock = 0, resetn = 0, clash_ok;
    logic [28:0] cmd = '0, pins;
    logic [31:0] rnd = 32'hf8ec_b468;
    logic [8:0] mem [16];
    logic [9:0] q1 [4] = '{default: '0}, q2 [4] = '{default: '0};
    logic [7:0] rd1, rd2;
    logic [2:0] fl1, fl2;
    int mismatches = 0, n_checks = 0;
    logic [29:0] dir [11] = '{{2'b00, 4'h1, 8'haa, 2'b11, 4'h2, 8'hbb, 2'b11},
        {2'b00, 4'h1, 8'h00, 2'b01, 4'h2, 8'h00, 2'b01}, {2'b00, 4'h3, 8'hcc, 2'b10, 4'h3, 10'h1},
        {2'b00, 4'h3, 8'h00, 2'b01, 4'h3, 10'h1}, {2'b01, 4'h0, 8'hff, 2'b11, 4'h0, 10'h1},
        {2'b00, 4'h0, 8'h00, 2'b01, 4'h0, 10'h1}, {2'b00, 4'h0, 8'h00, 2'b01, 4'h0, 10'h1},
        {2'b10, 4'h5, 8'hdd, 2'b11, 4'h5, 8'hee, 2'b11}, {2'b00, 4'h5, 8'h00, 2'b01, 4'h5, 10'h1},
        {2'b00, 4'h5, 8'h55, 2'b10, 4'h0, 10'h0}, {2'b00, 4'h5, 8'h00, 2'b01, 4'h5, 10'h1}};
    ram_user_model u_user (.clock(clock), .clash_ok(clash_ok), .cmd(cmd), .pins(pins));
    ecc_protected_dual_port_ram dut (.clock(clock), .resetn(resetn),
        .inject_lsb_error_port_one(pins[28]), .port_one_addr(pins[27:24]),
        .port_one_wdata(pins[23:16]), .port_one_wr_en(pins[15]), .port_one_rd_en(pins[14]),
        .port_two_addr(pins[13:10]), .port_two_wdata(pins[9:2]), .port_two_wr_en(pins[1]),
        .port_two_rd_en(pins[0]), .port_one_rd_out(rd1), .port_one_fixed_flag(fl1[2]),
        .port_one_found_flag(fl1[1]), .port_one_uncorrectable_flag(fl1[0]),
        .port_two_rd_out(rd2), .port_two_fixed_flag(fl2[2]), .port_two_found_flag(fl2[1]),
        .port_two_uncorrectable_flag(fl2[0]));
    ////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Unknown word yields unknown flags: x ^ x stays x
    function logic [10:0] outs(input logic [8:0] w);
        return {w[7:0], w[8], w[8], w[8] ^ w[8]};
    endfunction : outs
    task put(input logic [29:0] c);
        @(posedge clock);
        {clash_ok, cmd} <= c;
    endtask : put
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////
    initial
    begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (resetn)
        begin
            for (int i = 3; i > 0; i--)
            begin
                q1[i] = q1[i - 1];
                q2[i] = q2[i - 1];
            end
            q1[0] = {pins[14], pins[15] ? {pins[28], pins[23:16]} : mem[pins[27:24]]};
            q2[0] = {pins[0], mem[pins[13:10]]};
            if (pins[1])
                mem[pins[13:10]] = {1'b0, pins[9:2]};
            if (pins[15])
                mem[pins[27:24]] = {pins[28], pins[23:16]};
            if (pins[15] && pins[1] && pins[27:24] == pins[13:10] &&
                {pins[28], pins[23:16]} != {1'b0, pins[9:2]})
                mem[pins[27:24]] = 'x;
        end
    end
    always @(negedge clock)
    begin
        if (resetn && q1[3][9]) `CHK({rd1, fl1}, outs(q1[3][8:0]))
        if (resetn && q2[3][9]) `CHK({rd2, fl2}, outs(q2[3][8:0]))
    end
    initial
    begin
        #100us;
        mismatches++;
        finish_test;
    end
    initial
    begin
        clash_ok = 0;
        repeat (16) @(posedge clock);
        `CHK({rd1, fl1, rd2, fl2}, 22'h0)
        @(negedge clock) resetn = 1;
        for (int i = 0; i < 8; i++)
            put({2'b00, 4'(i), 8'(i * 29), 2'b10, 4'(i + 8), 8'(i * 7), 2'b10});
        foreach (dir[i])
            put(dir[i]);
        repeat (6) put('0);
        $display("directed test done");
        repeat (3000)
        begin
            rnd = lfsr(rnd);
            put({1'b0, &rnd[31:29], rnd[27:0]});
        end
        repeat (6) put('0);
        $display("random test done");
        finish_test;
    end
endmodule : ecc_protected_dual_port_ram_tb_top
